/* File: logic/static_mac_vlan_lookup.sv */
// static address table and vlan table lookup for a three-port switch
`timescale 1ns/10ps
module static_mac_vlan_lookup (
   input  wire logic        i_ref_clk,        // switch clock
   input  wire logic        i_rst_n,          // async reset, active low
   // host table access, indirect
   input  wire logic        i_tbl_wr,         // write strobe
   input  wire logic        i_tbl_rd,         // read strobe
   input  wire logic        i_tbl_sel,        // 0 static, 1 vlan
   input  wire logic [3:0]  i_tbl_idx,        // entry index
   input  wire logic [57:0] i_tbl_wdata,      // entry write data
   output logic [57:0]      o_tbl_rdata,      // entry read data
   output logic             o_tbl_rvalid,     // read data pulse
   // port configuration
   input  wire logic        i_vlan_mode,      // 802.1q mode enable
   input  wire logic [2:0]  i_port_tx_en,     // per-port transmit enable
   input  wire logic [2:0]  i_port_rx_en,     // per-port receive enable
   // lookup request from the forwarding engine
   input  wire logic        i_lkup_req,       // request pulse
   input  wire logic        i_lkup_is_sa,     // 1 source, 0 destination
   input  wire logic [47:0] i_lkup_mac,       // address to look up
   input  wire logic [1:0]  i_lkup_port,      // ingress port 0..2
   input  wire logic        i_lkup_tagged,    // frame carries a tag
   input  wire logic [11:0] i_lkup_tag_vid,   // vid in the tag
   input  wire logic [11:0] i_lkup_def_vid,   // ingress port default vid
   input  wire logic        i_dyn_hit,        // dynamic table hit
   input  wire logic [2:0]  i_dyn_ports,      // dynamic table ports
   // lookup answer
   output logic             o_res_valid,      // answer pulse
   output logic             o_res_is_sa,      // answer is for a source lookup
   output logic [2:0]       o_fwd_ports,      // egress port mask
   output logic             o_fwd_drop,       // frame dropped
   output logic             o_static_hit,     // static entry used
   output logic             o_learn,          // source should be learned
   output logic [3:0]       o_res_gid         // group id used
);
   // tables
   logic [57:0] static_tbl [lookup_pkg::STATIC_DEPTH]; // static entries
   logic [19:0] vlan_tbl   [lookup_pkg::VLAN_DEPTH];   // vlan entries

   // request stage
   logic        s1_valid;                     // request held
   logic        s1_is_sa;                     // source lookup
   logic [47:0] s1_mac;                       // address
   logic [1:0]  s1_port;                      // ingress port
   logic [11:0] s1_vid;                       // resolved vid
   logic        s1_dyn_hit;                   // dynamic hit
   logic [2:0]  s1_dyn_ports;                 // dynamic ports
   logic        s1_vmode;                     // vlan mode at request
   logic [11:0] next_vid;                     // vid chosen at request

   // decision signals
   logic        vlan_hit;                     // vid found
   logic [3:0]  vlan_idx;                     // matching vlan entry
   logic [3:0]  grp;                          // group id for lookups
   logic        vlan_ok;                      // vid accepted
   logic [lookup_pkg::STATIC_DEPTH-1:0] st_hit; // per-entry hits
   logic        st_any;                       // some static entry hit
   logic [2:0]  st_idx;                       // winning static entry
   logic [57:0] st_entry;                     // winning entry
   logic [2:0]  ing_bit;                      // ingress port as mask
   logic [2:0]  raw_ports;                    // ports before enables
   logic        bypass;                       // enables ignored
   logic [2:0]  next_ports;                   // final egress mask
   logic        next_learn;                   // learn source

   lookup_key_if key ();                      // key to comparators

   // untagged and null-vid frames take the port default
   always_comb begin
      if (i_lkup_tagged && (i_lkup_tag_vid != lookup_pkg::VID_NULL)) begin
         next_vid = i_lkup_tag_vid;
      end else begin
         next_vid = i_lkup_def_vid;
      end
   end

   // host writes; apart from reset, which clears every entry, nothing else alters the static table
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < lookup_pkg::STATIC_DEPTH; i++) begin
            static_tbl[i] <= lookup_pkg::SE_RESET;
         end
      end else if (i_tbl_wr && (i_tbl_sel == lookup_pkg::SEL_STATIC)
                   && (i_tbl_idx < 4'(lookup_pkg::STATIC_DEPTH))) begin
         static_tbl[i_tbl_idx[2:0]] <= i_tbl_wdata;
      end
   end

   // vlan table writes
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < lookup_pkg::VLAN_DEPTH; i++) begin
            vlan_tbl[i] <= lookup_pkg::VE_RESET;
         end
      end else if (i_tbl_wr && (i_tbl_sel == lookup_pkg::SEL_VLAN)) begin
         vlan_tbl[i_tbl_idx] <= i_tbl_wdata[19:0];
      end
   end

   // host reads, one cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tbl_rdata  <= 58'h0;
         o_tbl_rvalid <= 1'b0;
      end else begin
         o_tbl_rvalid <= i_tbl_rd;
         if (i_tbl_rd) begin
            if (i_tbl_sel == lookup_pkg::SEL_VLAN) begin
               o_tbl_rdata <= {38'h0, vlan_tbl[i_tbl_idx]};
            end else if (i_tbl_idx < 4'(lookup_pkg::STATIC_DEPTH)) begin
               o_tbl_rdata <= static_tbl[i_tbl_idx[2:0]];
            end else begin
               o_tbl_rdata <= 58'h0;          // beyond the static table
            end
         end
      end
   end

   // capture the request and dynamic table answer
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_valid     <= 1'b0;
         s1_is_sa     <= 1'b0;
         s1_mac       <= 48'h0;
         s1_port      <= 2'h0;
         s1_vid       <= 12'h0;
         s1_dyn_hit   <= 1'b0;
         s1_dyn_ports <= 3'h0;
         s1_vmode     <= 1'b0;
      end else begin
         s1_valid <= i_lkup_req;
         if (i_lkup_req) begin
            s1_is_sa     <= i_lkup_is_sa;
            s1_mac       <= i_lkup_mac;
            s1_port      <= i_lkup_port;
            s1_vid       <= next_vid;
            s1_dyn_hit   <= i_dyn_hit;
            s1_dyn_ports <= i_dyn_ports;
            s1_vmode     <= i_vlan_mode;
         end
      end
   end

   // vid search, lowest valid entry wins
   always_comb begin
      vlan_hit = 1'b0;
      vlan_idx = 4'h0;
      for (int i = lookup_pkg::VLAN_DEPTH - 1; i >= 0; i--) begin
         if (vlan_tbl[i][lookup_pkg::VE_VALID_BIT] &&
             (vlan_tbl[i][lookup_pkg::VE_VID_HI:lookup_pkg::VE_VID_LO] == s1_vid)) begin
            vlan_hit = 1'b1;
            vlan_idx = 4'(i);
         end
      end
      vlan_ok = ~s1_vmode | vlan_hit;
      if (s1_vmode) begin
         grp = vlan_tbl[vlan_idx][lookup_pkg::VE_GID_HI:lookup_pkg::VE_GID_LO];
      end else begin
         grp = lookup_pkg::GID_NONE;
      end
   end

   // key to the static comparators
   assign key.mac = s1_mac;
   assign key.gid = grp;

   // one comparator per static entry
   for (genvar g = 0; g < lookup_pkg::STATIC_DEPTH; g++) begin : g_static
      static_entry_match u_match (
         .key     (key.match),
         .i_entry (static_tbl[g]),
         .o_hit   (st_hit[g])
      );
   end

   // static priority, lowest index wins
   always_comb begin
      st_idx = 3'h0;
      for (int i = lookup_pkg::STATIC_DEPTH - 1; i >= 0; i--) begin
         if (st_hit[i]) begin
            st_idx = 3'(i);
         end
      end
      st_any   = |st_hit;
      st_entry = static_tbl[st_idx];
   end

   // forwarding decision
   always_comb begin
      ing_bit    = 3'h1 << s1_port;
      raw_ports  = lookup_pkg::PORTS_NONE;
      bypass     = 1'b0;
      next_ports = lookup_pkg::PORTS_NONE;
      next_learn = 1'b0;
      if (s1_is_sa) begin
         // source: dynamic table only, static result not consulted
         next_learn = vlan_ok & ~s1_dyn_hit;
      end else if (vlan_ok) begin
         if (st_any) begin
            // static wins over dynamic
            raw_ports = st_entry[lookup_pkg::SE_PORT_HI:lookup_pkg::SE_PORT_LO];
            if (raw_ports == lookup_pkg::PORTS_ALL) begin
               raw_ports = lookup_pkg::PORTS_ALL & ~ing_bit;
            end
            bypass = st_entry[lookup_pkg::SE_BYP_BIT];
         end else if (s1_dyn_hit) begin
            raw_ports = s1_dyn_ports & ~ing_bit;
         end else if (s1_vmode) begin
            // flood to the vlan members
            raw_ports = vlan_tbl[vlan_idx][lookup_pkg::VE_MEM_HI:lookup_pkg::VE_MEM_LO]
                      & ~ing_bit;
         end else begin
            raw_ports = lookup_pkg::PORTS_ALL & ~ing_bit;
         end
         if (bypass) begin
            next_ports = raw_ports;
         end else if (i_port_rx_en[s1_port]) begin
            next_ports = raw_ports & i_port_tx_en;
         end else begin
            next_ports = lookup_pkg::PORTS_NONE;             // receive disabled
         end
      end
   end

   // registered answer
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_res_valid  <= 1'b0;
         o_res_is_sa  <= 1'b0;
         o_fwd_ports  <= 3'h0;
         o_fwd_drop   <= 1'b0;
         o_static_hit <= 1'b0;
         o_learn      <= 1'b0;
         o_res_gid    <= 4'h0;
      end else begin
         o_res_valid <= s1_valid;
         if (s1_valid) begin
            o_res_is_sa  <= s1_is_sa;
            o_fwd_ports  <= next_ports;
            o_fwd_drop   <= ~s1_is_sa & (next_ports == lookup_pkg::PORTS_NONE);
            o_static_hit <= ~s1_is_sa & vlan_ok & st_any;
            o_learn      <= next_learn;
            o_res_gid    <= grp;
         end
      end
   end
endmodule // static_mac_vlan_lookup

/* File: include/lookup_pkg.sv */
// constants for the static address and vlan table lookup block
package lookup_pkg;
   // table geometry
   localparam int PORT_N       = 3;            // switch ports
   localparam int STATIC_DEPTH = 8;            // static address entries
   localparam int STATIC_IDX_W = 3;            // static entry index width
   localparam int VLAN_DEPTH   = 16;           // vlan entries, one per active group
   localparam int VLAN_IDX_W   = 4;            // vlan entry index width
   localparam int TBL_IDX_W    = 4;            // host index port width

   // static address entry layout
   localparam int SE_W         = 58;           // entry width
   localparam int SE_GID_HI    = 57;           // forwarding group id, msb
   localparam int SE_GID_LO    = 54;           // forwarding group id, lsb
   localparam int SE_KEY_BIT   = 53;           // group key select
   localparam int SE_BYP_BIT   = 52;           // port enable bypass
   localparam int SE_VALID_BIT = 51;           // entry valid
   localparam int SE_PORT_HI   = 50;           // destination mask, msb
   localparam int SE_PORT_LO   = 48;           // destination mask, lsb
   localparam int SE_MAC_HI    = 47;           // address, msb
   localparam int SE_MAC_LO    = 0;            // address, lsb
   localparam logic [57:0] SE_RESET = 58'h0;   // static entry reset value

   // vlan entry layout
   localparam int VE_W         = 20;           // entry width
   localparam int VE_VALID_BIT = 19;           // entry valid
   localparam int VE_MEM_HI    = 18;           // member mask, msb
   localparam int VE_MEM_LO    = 16;           // member mask, lsb
   localparam int VE_GID_HI    = 15;           // group id, msb
   localparam int VE_GID_LO    = 12;           // group id, lsb
   localparam int VE_VID_HI    = 11;           // vlan id, msb
   localparam int VE_VID_LO    = 0;            // vlan id, lsb
   localparam logic [19:0] VE_RESET = 20'hf0001; // valid, all members, vid 1

   // encodings
   localparam logic [2:0]  PORTS_ALL = 3'h7;   // every port / broadcast code
   localparam logic [2:0]  PORTS_NONE = 3'h0;  // no port
   localparam logic [11:0] VID_NULL  = 12'h000; // null vid in a tag
   localparam logic [3:0]  GID_NONE  = 4'h0;   // group id when vlan mode is off
   localparam logic        SEL_STATIC = 1'b0;  // host access to static table
   localparam logic        SEL_VLAN   = 1'b1;  // host access to vlan table
endpackage

/* File: include/lookup_key_if.sv */
// search key carried from the lookup stage to the static entry comparators
`timescale 1ns/10ps
interface lookup_key_if;
   logic [47:0] mac;                           // address under search
   logic [3:0]  gid;                           // group id under search
   modport drive (output mac, output gid);     // lookup stage side
   modport match (input mac, input gid);       // comparator side
endinterface // lookup_key_if

/* File: logic/static_entry_match.sv */
// one static address entry comparator
`timescale 1ns/10ps
module static_entry_match (
   lookup_key_if.match       key,              // search key
   input  wire logic [57:0]  i_entry,          // stored static entry
   output logic              o_hit             // entry matches key
);
   logic addr_eq;                              // address part equal
   logic gid_eq;                               // group part equal

   // address compare always, group compare only when the entry asks
   always_comb begin
      addr_eq = (i_entry[lookup_pkg::SE_MAC_HI:lookup_pkg::SE_MAC_LO] == key.mac);
      gid_eq  = (i_entry[lookup_pkg::SE_GID_HI:lookup_pkg::SE_GID_LO] == key.gid);
      o_hit   = i_entry[lookup_pkg::SE_VALID_BIT] & addr_eq
              & (~i_entry[lookup_pkg::SE_KEY_BIT] | gid_eq);
   end
endmodule // static_entry_match

/* File: tb/static_mac_vlan_lookup_asserts.sv */
// port-level assertions for the static address and vlan lookup block
`timescale 1ns/10ps
module static_mac_vlan_lookup_asserts (
   input  wire logic       i_ref_clk,    // clock
   input  wire logic       i_rst_n,      // reset, active low
   input  wire logic       i_tbl_rd,     // host read strobe
   input  wire logic       i_vlan_mode,  // vlan mode
   input  wire logic [2:0] i_port_tx_en, // tx enables
   input  wire logic       i_lkup_req,   // lookup request
   input  wire logic       i_lkup_is_sa, // source lookup
   input  wire logic [1:0] i_lkup_port,  // ingress port
   input  wire logic       i_dyn_hit,    // dynamic hit
   input  wire logic [2:0] i_dyn_ports,  // dynamic ports
   input  wire logic       o_tbl_rvalid, // read pulse
   input  wire logic       o_res_valid,  // answer pulse
   input  wire logic       o_res_is_sa,  // answer kind
   input  wire logic [2:0] o_fwd_ports,  // egress mask
   input  wire logic       o_fwd_drop,   // drop flag
   input  wire logic       o_static_hit, // static entry used
   input  wire logic       o_learn,      // learn flag
   input  wire logic [3:0] o_res_gid     // group id used
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // every request answered two edges on, kind kept
   property p_ans;
      i_lkup_req |-> ##2 o_res_valid && o_res_is_sa == $past(i_lkup_is_sa, 2);
   endproperty
   a_ans: assert property (p_ans) else $error("lookup answer missing or wrong kind");
   // no answer without a request
   property p_cause; o_res_valid |-> $past(i_lkup_req, 2); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   // source lookups never use the static table
   property p_sa;
      o_res_valid && o_res_is_sa |-> !o_static_hit && o_fwd_ports == 3'h0;
   endproperty
   a_sa: assert property (p_sa) else $error("source lookup used static result");
   // known source is not learned again
   property p_lrn; o_res_valid && o_res_is_sa && $past(i_dyn_hit, 2) |-> !o_learn; endproperty
   a_lrn: assert property (p_lrn) else $error("known source learned");
   // group id zero when vlan mode off
   property p_gid; o_res_valid && !$past(i_vlan_mode, 2) |-> o_res_gid == 4'h0; endproperty
   a_gid: assert property (p_gid) else $error("group id without vlan mode");
   // with vlan mode off, dynamic result confines ports when static missed
   property p_dyn; o_res_valid && !o_res_is_sa && !o_static_hit && $past(i_dyn_hit, 2)
      && !$past(i_vlan_mode, 2) |-> (o_fwd_ports & ~$past(i_dyn_ports, 2)) == 3'h0; endproperty
   a_dyn: assert property (p_dyn) else $error("ports outside dynamic result");
   // without a static override, tx enables mask the ports
   property p_tx; o_res_valid && !o_static_hit |-> (o_fwd_ports & ~$past(i_port_tx_en)) == 3'h0;
   endproperty
   a_tx: assert property (p_tx) else $error("port sent with tx disabled");
   // destination drop flag matches an empty mask
   property p_drop;
      o_res_valid && !o_res_is_sa |-> o_fwd_drop == (o_fwd_ports == 3'h0);
   endproperty
   a_drop: assert property (p_drop) else $error("drop flag disagrees with ports");
   // dropped frame neither forwarded nor learned
   property p_dl; o_res_valid && o_fwd_drop |-> !o_learn && o_fwd_ports == 3'h0; endproperty
   a_dl: assert property (p_dl) else $error("dropped frame forwarded or learned");
   // without a static entry the ingress port never gets its own frame back
   property p_ing;
      o_res_valid && !o_res_is_sa && !o_static_hit
         |-> (o_fwd_ports & (3'h1 << $past(i_lkup_port, 2))) == 3'h0;
   endproperty
   a_ing: assert property (p_ing) else $error("ingress port in flood or dynamic ports");
   // table read answers on the next edge
   property p_rd; i_tbl_rd |=> o_tbl_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("table read not answered");
endmodule // static_mac_vlan_lookup_asserts
bind static_mac_vlan_lookup static_mac_vlan_lookup_asserts static_mac_vlan_lookup_asserts_inst (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tbl_rd(i_tbl_rd), .i_vlan_mode(i_vlan_mode),
   .i_port_tx_en(i_port_tx_en), .i_lkup_req(i_lkup_req), .i_lkup_is_sa(i_lkup_is_sa),
   .i_lkup_port(i_lkup_port),
   .i_dyn_hit(i_dyn_hit), .i_dyn_ports(i_dyn_ports), .o_tbl_rvalid(o_tbl_rvalid),
   .o_res_valid(o_res_valid), .o_res_is_sa(o_res_is_sa), .o_fwd_ports(o_fwd_ports),
   .o_fwd_drop(o_fwd_drop), .o_static_hit(o_static_hit), .o_learn(o_learn),
   .o_res_gid(o_res_gid));

/* File: tb/dyn_table_model.sv */
// dynamic address table stand-in answering the lookup block
`timescale 1ns/10ps
module dyn_table_model (
   input  wire logic [47:0] i_mac,   // address presented
   output logic             o_hit,   // dynamic hit
   output logic [2:0]       o_ports  // learned ports
);
   // addresses with top nibble a count as learned
   assign o_hit   = (i_mac[47:44] == 4'ha);
   // learned port from low bits, never empty
   assign o_ports = i_mac[2:0] | 3'h1;
endmodule // dyn_table_model

/* File: tb/static_mac_vlan_lookup_test.sv */
// self-checking bench for the static address and vlan lookup block
`timescale 1ns/10ps
module static_mac_vlan_lookup_test;
   logic        clk = 1'b0, rst_n = 1'b0;       // clock, reset
   logic        wr = 1'b0, rd = 1'b0, sel = 1'b0; // host strobes
   logic [3:0]  idx = 4'h0;                     // entry index
   logic [57:0] wd = 58'h0, rdat;               // host data
   logic        rv, val, isa, drop, sh, lrn, dh; // answer flags
   logic        vm = 1'b0, req = 1'b0, sa = 1'b0, tg = 1'b0; // request fields
   logic [2:0]  tx = 3'h0, rx = 3'h0, dp, fp;   // enables, ports
   logic [1:0]  pt = 2'h0;                      // ingress port
   logic [47:0] mac = 48'h0;                    // address
   logic [11:0] tv = 12'h0, dv = 12'h0;         // tag and default vid
   logic [3:0]  gid;                            // group id out
   logic [57:0] st [8];                         // static shadow
   logic [19:0] vt [16];                        // vlan shadow
   logic [31:0] seed = 32'h2810bfb3;            // xorshift state
   logic [31:0] r;                              // random word
   int          miscompares = 0, total_checks = 0; // counters
   // free-running 50 mhz clock
   always #10 clk = ~clk;
   static_mac_vlan_lookup static_mac_vlan_lookup_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_tbl_wr(wr), .i_tbl_rd(rd), .i_tbl_sel(sel), .i_tbl_idx(idx), .i_tbl_wdata(wd),
      .o_tbl_rdata(rdat), .o_tbl_rvalid(rv), .i_vlan_mode(vm), .i_port_tx_en(tx),
      .i_port_rx_en(rx), .i_lkup_req(req), .i_lkup_is_sa(sa), .i_lkup_mac(mac),
      .i_lkup_port(pt), .i_lkup_tagged(tg), .i_lkup_tag_vid(tv), .i_lkup_def_vid(dv),
      .i_dyn_hit(dh), .i_dyn_ports(dp), .o_res_valid(val), .o_res_is_sa(isa),
      .o_fwd_ports(fp), .o_fwd_drop(drop), .o_static_hit(sh), .o_learn(lrn), .o_res_gid(gid));
   dyn_table_model dyn_table_model_inst (.i_mac(mac), .o_hit(dh), .o_ports(dp));
   // xorshift generator
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // compare and count
   task automatic chk(input logic [57:0] got, input logic [57:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // counts, verdict, end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // host write of one entry, shadow follows
   task automatic hw(input logic s, input logic [3:0] i, input logic [57:0] d);
      @(posedge clk);
      {wr, sel, idx, wd} <= {1'b1, s, i, d};
      @(posedge clk);
      wr <= 1'b0;
      if (!s && i < 4'h8) st[i[2:0]] = d;
      if (s) vt[i] = d[19:0];
   endtask
   // host read, answer one edge later
   task automatic hr(input logic s, input logic [3:0] i, input logic [57:0] x);
      @(posedge clk);
      {rd, sel, idx} <= {1'b1, s, i};
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({57'h0, rv}, 58'h1);
      chk(rdat, x);
   endtask
   // expected {vid ok, drop, static hit, learn, gid, ports}
   function automatic logic [10:0] expect_res();
      logic [11:0] vid;
      logic [3:0]  g;
      logic [2:0]  p, mem, ing;
      logic        ok, hit, byp;
      vid = (tg && tv != 12'h0) ? tv : dv;
      {ok, g, mem, hit, byp} = {!vm, 4'h0, 3'h7, 2'b00};
      for (int i = 15; i >= 0; i--) begin
         if (vm && vt[i][19] && vt[i][11:0] == vid) begin
            {ok, g, mem} = {1'b1, vt[i][15:12], vt[i][18:16]};
         end
      end
      ing = 3'h1 << pt;
      p = (dh ? dp : mem) & ~ing;
      for (int i = 7; i >= 0; i--)
         if (st[i][51] && st[i][47:0] == mac && (!st[i][53] || st[i][57:54] == g))
            {hit, byp, p} = {1'b1, st[i][52], st[i][50:48]};
      if (hit && p == 3'h7) p = 3'h7 & ~ing;
      if (!byp) p = rx[pt] ? (p & tx) : 3'h0;
      if (!ok || sa) p = 3'h0;
      // source answers never flag a drop; an unknown vid empties the ports
      return {ok, !sa && p == 3'h0, hit && !sa && ok, sa && ok && !dh, g, p};
   endfunction
   // one lookup with random port, vids and enables
   task automatic lk(input logic s, input logic [47:0] m, input logic v);
      logic [10:0] e;
      logic [9:0]  k;
      r = rnd();
      @(posedge clk);
      {req, sa, mac, vm, tg, tv, dv} <= {1'b1, s, m, v, r[0], {9'h0, r[3:1]}, {9'h0, r[6:4]}};
      {pt, tx, rx} <= {(r[8:7] == 2'h3) ? 2'h2 : r[8:7], r[11:9] | r[14:12], r[17:15] | r[20:18]};
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      #1;
      e = expect_res();
      k = e[10] ? 10'h3ff : 10'h387; // group id means nothing for an unknown vid
      chk({56'h0, val, isa}, {56'h0, 1'b1, s});
      chk({48'h0, {drop, sh, lrn, gid, fp} & k}, {48'h0, e[9:0] & k});
   endtask
   // main sequence
   initial begin
      for (int i = 0; i < 8; i++) st[i] = 58'h0;
      for (int i = 0; i < 16; i++) vt[i] = 20'hf0001;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      hr(1'b0, 4'h3, 58'h0);
      hr(1'b1, 4'h9, 58'hf0001);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         hw(1'b0, i[3:0], {2'h0, r[1:0], r[4], r[5], r[6] | r[7], r[10:8],
            (i[0] ? 4'h5 : 4'ha), 41'h0, i[2:0]});
      end
      r = rnd();
      hw(1'b0, 4'h8, {r[25:0], rnd()});
      hr(1'b0, 4'h8, 58'h0);
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         hw(1'b1, i[3:0], {38'h0, i != 4, r[2:0], 2'h0, r[4:3], 9'h0, i[2:0] + 3'h1});
      end
      for (int i = 0; i < 8; i++) hr(1'b0, i[3:0], st[i]);
      for (int i = 0; i < 6; i++) hr(1'b1, i[3:0], {38'h0, vt[i]});
      repeat (600) begin
         r = rnd();
         lk(r[0], {(r[1] ? 4'ha : 4'h5), 41'h0, r[4:2]}, r[5]);
      end
      // mid-run reset: answers clear, tables return to their defaults
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk(rdat, 58'h0);
      chk({45'h0, rv, val, isa, drop, sh, lrn, gid, fp}, 58'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      hr(1'b0, 4'h2, 58'h0);
      hr(1'b1, 4'h5, 58'hf0001);
      final_report();
   end
endmodule // static_mac_vlan_lookup_test
